// file: hw/glca_defs.vh
// Constants for the lane-pair coding, alignment and rate-match block
`ifndef GLCA_DEFS_VH
`define GLCA_DEFS_VH
// Register indices; byte address is four times the index
`define GLCA_IDX_CTRL1 6'h11
`define GLCA_IDX_CTRL6 6'h18
`define GLCA_IDX_STAT 6'h1a
// Control 1 fields and reset value
`define GLCA_B_NIBBLE 0
`define GLCA_B_CODE 7
`define GLCA_B_COMMA 8
`define GLCA_CTRL1_RST 16'h0100
// Control 6 fields and reset value
`define GLCA_B_RATE 0
`define GLCA_B_IDLE1 1
`define GLCA_CTRL6_RST 16'h0001
// Characters as {k, data}
`define GLCA_K285 9'h1bc
`define GLCA_D56 9'h0c5
`define GLCA_D162 9'h050
// Invalid group sent for a bad control value, j..a order
`define GLCA_INV_CODE 10'h03f
// Timing: clock period and serial bit period in ns
`define GLCA_CLK_NS 100
`define GLCA_BIT_NS 800
`define GLCA_BIT_DIV (`GLCA_BIT_NS / `GLCA_CLK_NS)
`define GLCA_WORD_BITS 10
`endif

// file: hw/glca_lane_pair.v
// Lane pair: 8b/10b coding, serializer, comma alignment, rate matching
`timescale 1ns/1ps
`include "glca_defs.vh"
module glca_lane_pair #(
  parameter AW = 4,
  parameter BIT_DIV = `GLCA_BIT_DIV
) (
  input wire CLK,
  input wire RST_N,
  input wire [7:0] WB_ADR_I,
  input wire [31:0] WB_DAT_I,
  input wire [3:0] WB_SEL_I,
  input wire WB_WE_I,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  output reg [31:0] WB_DAT_O,
  output reg WB_ACK_O,
  input wire CODE_SEL,
  input wire [19:0] TX_DATA,
  output wire [1:0] TX_SER,
  input wire [1:0] RX_SER,
  input wire [1:0] RX_REC_CLK,
  output reg [9:0] RX_PARALLEL_BUS,
  output reg RX_PAIR_CLOCK_TRUE,
  output reg RX_PAIR_CLOCK_COMP,
  output reg [1:0] RX_BYTE_CLOCKS
);
  localparam [31:0] BIT_M1 = BIT_DIV - 1;
  localparam [7:0] BIT_LAST = BIT_M1[7:0];
  localparam [AW:0] FULL = {1'b1, {AW{1'b0}}};
  localparam [AW:0] HI = FULL - (FULL >> 2);
  localparam [AW:0] LO = FULL >> 2;

  // Encode {k,data} at disparity rd; returns {rd_out, code j..a}
  function [10:0] enc;
    input [8:0] kd;
    input rd;
    reg [5:0] s6;
    reg [3:0] s4;
    reg [4:0] x;
    reg [2:0] y;
    reg [9:0] w;
    reg k28, kok, r1, r2, f4;
    integer n6, n4, i;
    begin
      x = kd[4:0];
      y = kd[7:5];
      k28 = kd[8] && x == 5'h1c;
      kok = k28 || (y == 3'h7 && (x == 5'h17 || x == 5'h1b ||
            x == 5'h1d || x == 5'h1e));
      case (x)
        5'h00: s6 = 6'h27; 5'h01: s6 = 6'h1d; 5'h02: s6 = 6'h2d;
        5'h03: s6 = 6'h31; 5'h04: s6 = 6'h35; 5'h05: s6 = 6'h29;
        5'h06: s6 = 6'h19; 5'h07: s6 = 6'h38; 5'h08: s6 = 6'h39;
        5'h09: s6 = 6'h25; 5'h0a: s6 = 6'h15; 5'h0b: s6 = 6'h34;
        5'h0c: s6 = 6'h0d; 5'h0d: s6 = 6'h2c; 5'h0e: s6 = 6'h1c;
        5'h0f: s6 = 6'h17; 5'h10: s6 = 6'h1b; 5'h11: s6 = 6'h23;
        5'h12: s6 = 6'h13; 5'h13: s6 = 6'h32; 5'h14: s6 = 6'h0b;
        5'h15: s6 = 6'h2a; 5'h16: s6 = 6'h1a; 5'h17: s6 = 6'h3a;
        5'h18: s6 = 6'h33; 5'h19: s6 = 6'h26; 5'h1a: s6 = 6'h16;
        5'h1b: s6 = 6'h36; 5'h1c: s6 = k28 ? 6'h0f : 6'h0e;
        5'h1d: s6 = 6'h2e; 5'h1e: s6 = 6'h1e;
        default: s6 = 6'h2b;
      endcase
      n6 = 0;
      for (i = 0; i < 6; i = i + 1)
        n6 = n6 + s6[i];
      // Unbalanced groups and D.7 take the complement at positive rd
      if (rd && (n6 != 3 || x == 5'h07))
        s6 = ~s6;
      r1 = (n6 != 3) ? ~rd : rd;
      case (y)
        3'h0: s4 = 4'hb; 3'h1: s4 = 4'h9; 3'h2: s4 = 4'h5;
        3'h3: s4 = 4'hc; 3'h4: s4 = 4'hd; 3'h5: s4 = 4'ha;
        3'h6: s4 = 4'h6;
        default: s4 = 4'he;
      endcase
      // Alternate x.7 avoids a run of five equal bits
      if (y == 3'h7 && (kd[8] || (!r1 && (x == 5'h11 || x == 5'h12 ||
          x == 5'h14)) || (r1 && (x == 5'h0b || x == 5'h0d ||
          x == 5'h0e))))
        s4 = 4'h7;
      n4 = s4[0] + s4[1] + s4[2] + s4[3];
      f4 = r1 ? (n4 != 2 || y == 3'h3) : (k28 && n4 == 2 && y != 3'h3);
      if (f4)
        s4 = ~s4;
      r2 = (n4 != 2) ? ~r1 : r1;
      w = {s6, s4};
      for (i = 0; i < 10; i = i + 1)
        enc[i] = w[9 - i];
      enc[10] = r2;
      if (kd[8] && !kok)
        enc = {rd, `GLCA_INV_CODE};
    end
  endfunction

  // Decode group c at rd; returns {err, rd_out, k, data}
  function [10:0] dec;
    input [9:0] c;
    input rd;
    reg [10:0] e;
    reg [9:0] i;
    reg hit, miss;
    begin
      dec = {1'b1, rd, 9'h0ff};
      hit = 1'b0;
      miss = 1'b0;
      for (i = 10'h000; i < 10'h200; i = i + 10'h001) begin
        e = enc(i[8:0], rd);
        if (!hit && e[9:0] == c && e[9:0] != `GLCA_INV_CODE) begin
          hit = 1'b1;
          dec = {1'b0, e[10], i[8:0]};
        end
        e = enc(i[8:0], !rd);
        if (e[9:0] == c && e[9:0] != `GLCA_INV_CODE)
          miss = 1'b1;
      end
      if (!hit)
        dec = {1'b1, (miss ? rd : rd), 1'b0, 8'hff};
    end
  endfunction

  // Match a buffered word against a character in either coding mode
  function is_w;
    input [9:0] w;
    input coded;
    input [8:0] kd;
    reg [10:0] e0, e1;
    begin
      e0 = enc(kd, 1'b0);
      e1 = enc(kd, 1'b1);
      is_w = coded ? (w == {1'b0, kd}) :
             (w == e0[9:0] || w == e1[9:0]);
    end
  endfunction

  reg [15:0] ctrl1_reg, ctrl6_reg;
  reg [2:0] code_sy_reg;
  reg code_st_reg;
  reg [7:0] div_reg;
  reg [3:0] bit_cnt_reg;
  wire [19:0] out_all, hold_all;
  wire [9:0] half_all;
  wire [1:0] bclk_all, algn_all, cerr_all;
  wire [2*(AW+1)-1:0] lvl_all;
  wire code_en = code_st_reg | ctrl1_reg[`GLCA_B_CODE];
  wire comma_en = ctrl1_reg[`GLCA_B_COMMA];
  wire nibble = ctrl1_reg[`GLCA_B_NIBBLE];
  wire rate_en = ctrl6_reg[`GLCA_B_RATE];
  wire idle1 = ctrl6_reg[`GLCA_B_IDLE1];
  wire bit_en = div_reg == BIT_LAST;
  wire ref_en = bit_en && bit_cnt_reg == 4'h9;
  wire fall_ev = bit_en && bit_cnt_reg == 4'h4;
  wire wb_hit = WB_CYC_I && WB_STB_I && !WB_ACK_O;

  // Wishbone slave: one wait state, unmapped reads zero, writes dropped
  always @(posedge CLK) begin
    if (!RST_N) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
      ctrl1_reg <= `GLCA_CTRL1_RST;
      ctrl6_reg <= `GLCA_CTRL6_RST;
    end else begin
      WB_ACK_O <= wb_hit;
      if (wb_hit) begin
        case (WB_ADR_I[7:2])
          `GLCA_IDX_CTRL1: WB_DAT_O <= {16'h0000, ctrl1_reg};
          `GLCA_IDX_CTRL6: WB_DAT_O <= {16'h0000, ctrl6_reg};
          `GLCA_IDX_STAT: WB_DAT_O <= {{(26 - 2 * AW){1'b0}}, lvl_all,
                                       algn_all, cerr_all};
          default: WB_DAT_O <= 32'h0000_0000;
        endcase
        if (WB_WE_I && WB_ADR_I[7:2] == `GLCA_IDX_CTRL1) begin
          if (WB_SEL_I[0])
            ctrl1_reg[7:0] <= WB_DAT_I[7:0];
          if (WB_SEL_I[1])
            ctrl1_reg[15:8] <= WB_DAT_I[15:8];
        end
        if (WB_WE_I && WB_ADR_I[7:2] == `GLCA_IDX_CTRL6) begin
          if (WB_SEL_I[0])
            ctrl6_reg[7:0] <= WB_DAT_I[7:0];
          if (WB_SEL_I[1])
            ctrl6_reg[15:8] <= WB_DAT_I[15:8];
        end
      end
    end
  end

  // Coding pin sync; the level moves only once stages two and three agree
  always @(posedge CLK) begin
    if (!RST_N) begin
      code_sy_reg <= 3'h0;
      code_st_reg <= 1'b0;
    end else begin
      code_sy_reg <= {code_sy_reg[1:0], CODE_SEL};
      if (code_sy_reg[2] == code_sy_reg[1])
        code_st_reg <= code_sy_reg[2];
    end
  end

  // Bit-rate enable and reference word enable, ten bits per word
  always @(posedge CLK) begin
    if (!RST_N) begin
      div_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
    end else begin
      div_reg <= bit_en ? 8'h00 : div_reg + 8'h01;
      if (bit_en)
        bit_cnt_reg <= ref_en ? 4'h0 : bit_cnt_reg + 4'h1;
    end
  end

  genvar l;
  generate
    for (l = 0; l < 2; l = l + 1) begin : g_lane
      reg [9:0] tx_sh_reg;
      reg tx_rd_reg, tx_ser_reg;
      reg [2:0] dsy_reg, csy_reg;
      reg cst_reg, rx_rd_reg, win_v_reg, pend_v_reg, primed_reg;
      reg bclk_reg, algn_reg, cerr_reg;
      reg [9:0] sr_reg, win_reg, pend_reg, hold_reg, prev_reg;
      reg [9:0] prev2_reg, half_src_reg;
      reg [4:0] half_reg;
      reg [3:0] cnt_reg;
      reg ins_reg;
      reg [9:0] mem [0:(1 << AW) - 1];
      reg [AW:0] wptr_reg, rptr_reg;
      wire [10:0] enc_w = enc(TX_DATA[l * 10 +: 9], tx_rd_reg);
      wire [9:0] tx_word = code_en ? enc_w[9:0] :
                           TX_DATA[l * 10 +: 10];
      wire rise = csy_reg[2] == csy_reg[1] && csy_reg[2] && !cst_reg;
      wire [9:0] sr_next = {dsy_reg[2], sr_reg[9:1]};
      wire comma = comma_en && sr_next[9:3] == 7'h7c;
      wire emit = rise && !comma && cnt_reg == 4'h9;
      wire [10:0] dw = dec(sr_next, rx_rd_reg);
      wire [9:0] word_in = code_en ? {1'b0, dw[8:0]} : sr_next;
      wire [AW:0] lvl = wptr_reg - rptr_reg;
      wire gap = is_w(prev2_reg, code_en, `GLCA_K285) &&
                 (is_w(prev_reg, code_en, `GLCA_D56) ||
                  is_w(prev_reg, code_en, `GLCA_D162));
      wire ins_go = rate_en && primed_reg && !ins_reg && gap &&
                    lvl < LO;
      wire [8:0] idle_2nd = idle1 ? `GLCA_D56 : `GLCA_D162;
      wire do_rd = primed_reg && !ins_reg && !ins_go && lvl != 0;
      // Coded mode sends a fresh set; raw mode replays the last set
      wire [9:0] out_w = ins_reg ? (code_en ? {1'b0, idle_2nd} :
                         prev2_reg) : ins_go ? (code_en ?
                         {1'b0, `GLCA_K285} : prev2_reg) :
                         do_rd ? mem[rptr_reg[AW-1:0]] : prev_reg;
      wire del = pend_v_reg && rate_en && lvl >= HI &&
                 is_w(pend_reg, code_en, `GLCA_K285) &&
                 (is_w(win_reg, code_en, `GLCA_D56) ||
                  is_w(win_reg, code_en, `GLCA_D162));

      // Transmit shifter; word loaded at the reference edge
      always @(posedge CLK) begin
        if (!RST_N) begin
          tx_sh_reg <= 10'h000;
          tx_ser_reg <= 1'b0;
          tx_rd_reg <= 1'b0;
        end else if (bit_en) begin
          tx_ser_reg <= tx_sh_reg[0];
          tx_sh_reg <= ref_en ? tx_word : {1'b0, tx_sh_reg[9:1]};
          if (ref_en && code_en)
            tx_rd_reg <= enc_w[10];
        end
      end
      assign TX_SER[l] = tx_ser_reg;

      // Link inputs pass three flops; edges taken when two and three agree
      always @(posedge CLK) begin
        if (!RST_N) begin
          dsy_reg <= 3'h0;
          csy_reg <= 3'h0;
          cst_reg <= 1'b0;
        end else begin
          dsy_reg <= {dsy_reg[1:0], RX_SER[l]};
          csy_reg <= {csy_reg[1:0], RX_REC_CLK[l]};
          if (csy_reg[2] == csy_reg[1])
            cst_reg <= csy_reg[2];
        end
      end

      // Deserializer, comma alignment, decode and byte clock
      always @(posedge CLK) begin
        if (!RST_N) begin
          sr_reg <= 10'h000;
          cnt_reg <= 4'h0;
          rx_rd_reg <= 1'b0;
          win_reg <= 10'h000;
          win_v_reg <= 1'b0;
          algn_reg <= 1'b0;
          cerr_reg <= 1'b0;
          bclk_reg <= 1'b0;
          half_reg <= 5'h00;
          half_src_reg <= 10'h000;
        end else begin
          win_v_reg <= emit;
          if (rise) begin
            sr_reg <= sr_next;
            if (comma) begin
              cnt_reg <= 4'h7;
              algn_reg <= 1'b1;
            end else
              cnt_reg <= emit ? 4'h0 : cnt_reg + 4'h1;
            // Byte clock: five recovered bits high, five low
            if (emit) begin
              bclk_reg <= 1'b1;
              half_reg <= word_in[4:0];
              half_src_reg <= word_in;
            end else if (cnt_reg == 4'h4) begin
              bclk_reg <= 1'b0;
              half_reg <= half_src_reg[9:5];
            end
          end
          if (emit) begin
            win_reg <= word_in;
            if (code_en) begin
              rx_rd_reg <= dw[9];
              cerr_reg <= dw[10];
            end
          end
        end
      end

      // Buffer write; a pending K28.5 waits to see if its set can drop
      always @(posedge CLK) begin
        if (!RST_N) begin
          pend_reg <= 10'h000;
          pend_v_reg <= 1'b0;
          wptr_reg <= {(AW + 1){1'b0}};
        end else if (win_v_reg) begin
          if (del)
            pend_v_reg <= 1'b0;
          else begin
            pend_reg <= win_reg;
            pend_v_reg <= 1'b1;
            if (pend_v_reg && lvl != FULL) begin
              mem[wptr_reg[AW-1:0]] <= pend_reg;
              wptr_reg <= wptr_reg + 1'b1;
            end
          end
        end
      end

      // Buffer read on the reference edge, with IDLE insertion
      always @(posedge CLK) begin
        if (!RST_N) begin
          rptr_reg <= {(AW + 1){1'b0}};
          primed_reg <= 1'b0;
          ins_reg <= 1'b0;
          hold_reg <= 10'h000;
          prev_reg <= 10'h000;
          prev2_reg <= 10'h000;
        end else begin
          if (lvl >= (FULL >> 1))
            primed_reg <= 1'b1;
          if (ref_en) begin
            ins_reg <= ins_go;
            if (do_rd)
              rptr_reg <= rptr_reg + 1'b1;
            hold_reg <= out_w;
            prev_reg <= out_w;
            prev2_reg <= prev_reg;
          end
        end
      end

      assign out_all[l * 10 +: 10] = out_w;
      assign hold_all[l * 10 +: 10] = hold_reg;
      assign half_all[l * 5 +: 5] = half_reg;
      assign bclk_all[l] = bclk_reg;
      assign algn_all[l] = algn_reg;
      assign cerr_all[l] = cerr_reg;
      assign lvl_all[l * (AW + 1) +: (AW + 1)] = lvl;
    end
  endgenerate

  // Receive bus and clocks; pair clocks fixed five-high, five-low always, byte clocks recovered in bypass
  always @(posedge CLK) begin
    if (!RST_N) begin
      RX_PARALLEL_BUS <= 10'h000;
      RX_PAIR_CLOCK_TRUE <= 1'b0;
      RX_PAIR_CLOCK_COMP <= 1'b1;
      RX_BYTE_CLOCKS <= 2'b00;
    end else begin
      if (ref_en) begin
        RX_PAIR_CLOCK_TRUE <= 1'b1;
        RX_PAIR_CLOCK_COMP <= 1'b0;
      end else if (fall_ev) begin
        RX_PAIR_CLOCK_TRUE <= 1'b0;
        RX_PAIR_CLOCK_COMP <= 1'b1;
      end
      if (nibble && !rate_en) begin
        // Bypass: each lane on its own recovered byte clock
        RX_PARALLEL_BUS <= {half_all[9:5], half_all[4:0]};
        RX_BYTE_CLOCKS <= bclk_all;
      end else if (ref_en) begin
        RX_BYTE_CLOCKS <= 2'b11;
        RX_PARALLEL_BUS <= nibble ? {out_all[14:10], out_all[4:0]} :
                           out_all[19:10];
      end else if (fall_ev) begin
        RX_BYTE_CLOCKS <= 2'b00;
        RX_PARALLEL_BUS <= nibble ? {hold_all[19:15], hold_all[9:5]} :
                           hold_all[9:0];
      end
    end
  end
endmodule

// file: tb/glca_lane_pair_properties.sv
// Port-level assertions for the lane-pair coding and rate-match block
`timescale 1ns/1ps
`include "glca_defs.vh"
module glca_lane_pair_chk #(
  parameter BIT_DIV = 8
) (
  input wire CLK,
  input wire RST_N,
  input wire [7:0] WB_ADR_I,
  input wire [31:0] WB_DAT_I,
  input wire [3:0] WB_SEL_I,
  input wire WB_WE_I,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire [31:0] WB_DAT_O,
  input wire WB_ACK_O,
  input wire [1:0] TX_SER,
  input wire RX_PAIR_CLOCK_TRUE,
  input wire RX_PAIR_CLOCK_COMP,
  input wire [1:0] RX_BYTE_CLOCKS
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic [7:0] hcnt;
  logic [7:0] tcnt;
  logic hval;
  logic tval;
  logic rate_on;
  wire [5:0] idx = WB_ADR_I[7:2];
  wire mapped = idx == `GLCA_IDX_CTRL1 || idx == `GLCA_IDX_CTRL6 ||
    idx == `GLCA_IDX_STAT;
  // Edge-to-edge counters; valid only once a first edge was seen, since
  // the phase at reset release is arbitrary
  always @(posedge CLK) begin
    if (!RST_N) begin
      hcnt <= 8'h00;
      tcnt <= 8'h00;
      hval <= 1'b0;
      tval <= 1'b0;
      rate_on <= 1'b1;
    end else begin
      hval <= hval | $changed(RX_PAIR_CLOCK_TRUE);
      hcnt <= $changed(RX_PAIR_CLOCK_TRUE) ? 8'h00 : hcnt + 8'h01;
      tval <= tval | $changed(TX_SER[0]);
      tcnt <= ($changed(TX_SER[0]) || tcnt == BIT_DIV - 1) ? 8'h00 :
        tcnt + 8'h01;
      // Shadow of the rate-match enable, tracked from bus writes
      if (WB_ACK_O && WB_WE_I && idx == `GLCA_IDX_CTRL6 && WB_SEL_I[0])
        rate_on <= WB_DAT_I[`GLCA_B_RATE];
    end
  end
  sequence s_take;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence s_answer;
    ##1 WB_ACK_O ##1 !WB_ACK_O;
  endsequence
  a_ack_next: assert property (s_take |-> s_answer)
    else $error("ack not a single pulse one cycle after request");
  a_ack_cause: assert property ($rose(WB_ACK_O) |->
    $past(WB_CYC_I && WB_STB_I)) else $error("ack without request");
  a_unmapped_zero: assert property (s_take ##0 (!WB_WE_I && !mapped) |=>
    WB_DAT_O == 32'h0) else $error("unmapped read not zero");
  a_upper_zero: assert property (WB_ACK_O |-> WB_DAT_O[31:16] == 16'h0)
    else $error("upper read bytes not zero");
  a_comp_inverse: assert property (
    RX_PAIR_CLOCK_COMP == !RX_PAIR_CLOCK_TRUE)
    else $error("pair clocks not complementary");
  a_pair_half: assert property (hval |-> hcnt < 5 * BIT_DIV &&
    (!$changed(RX_PAIR_CLOCK_TRUE) || hcnt == 5 * BIT_DIV - 1))
    else $error("pair clock half period wrong");
  a_tx_bit_time: assert property (tval && $changed(TX_SER[0]) |->
    tcnt == BIT_DIV - 1) else $error("serial bit off the bit grid");
  a_byte_copy: assert property (rate_on &&
    $stable(RX_PAIR_CLOCK_TRUE) |-> RX_BYTE_CLOCKS == {2{RX_PAIR_CLOCK_TRUE}})
    else $error("byte clocks not a copy of pair clock");
endmodule
bind glca_lane_pair glca_lane_pair_chk #(.BIT_DIV(BIT_DIV))
  glca_lane_pair_chk_i (
  .CLK(CLK), .RST_N(RST_N), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I),
  .WB_SEL_I(WB_SEL_I), .WB_WE_I(WB_WE_I), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .TX_SER(TX_SER), .RX_PAIR_CLOCK_TRUE(RX_PAIR_CLOCK_TRUE),
  .RX_PAIR_CLOCK_COMP(RX_PAIR_CLOCK_COMP), .RX_BYTE_CLOCKS(RX_BYTE_CLOCKS)
);

// file: tb/glca_link_src.sv
// Far-end serial source: repeats a 20-bit pattern on one lane
`timescale 1ns/1ps
module glca_link_src #(
  parameter real PHASE = 137.0
) (
  input wire [19:0] pat,
  input wire stop,
  output logic rclk,
  output logic ser
);
  integer i;
  // Recovered clock, parked only while stop is high; data moves on the falling edge so it
  // sits still a full bit around the rising edge that the block samples
  initial begin
    rclk = 1'b0;
    ser = 1'b0;
    #(PHASE);
    forever begin
      for (i = 0; i < 20; i = i + 1) begin
        // A stall parks the clock low between bits; no bit is lost
        while (stop)
          #100;
        ser = pat[i];
        #400 rclk = 1'b1;
        #400 rclk = 1'b0;
      end
    end
  end
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the lane-pair coding and rate-match block
`timescale 1ns/1ps
`include "glca_defs.vh"
module tb_top;
  localparam logic [7:0] A_C1 = {`GLCA_IDX_CTRL1, 2'b00};
  localparam logic [7:0] A_C6 = {`GLCA_IDX_CTRL6, 2'b00};
  localparam logic [7:0] A_ST = {`GLCA_IDX_STAT, 2'b00};
  localparam logic [19:0] KPAIR = {10'h283, 10'h17c};
  logic clk, rst_n, cyc, stb, we, code_sel, stop1;
  logic [7:0] adr;
  logic [31:0] wdat, rdat;
  logic [3:0] sel;
  logic [19:0] tx_data, pat0, pat1;
  wire [31:0] dat_o;
  wire ack, clk_t, clk_c;
  wire [1:0] tx_ser, rx_ser, rx_rclk, byte_clk;
  wire [9:0] bus;
  int errors, cmp_count, cycles;
  glca_lane_pair glca_lane_pair_i (.CLK(clk), .RST_N(rst_n),
    .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_SEL_I(sel), .WB_WE_I(we),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .CODE_SEL(code_sel), .TX_DATA(tx_data), .TX_SER(tx_ser),
    .RX_SER(rx_ser), .RX_REC_CLK(rx_rclk), .RX_PARALLEL_BUS(bus),
    .RX_PAIR_CLOCK_TRUE(clk_t), .RX_PAIR_CLOCK_COMP(clk_c),
    .RX_BYTE_CLOCKS(byte_clk));
  glca_link_src #(.PHASE(137.0)) glca_link_src_i0 (.pat(pat0),
    .stop(1'b0), .rclk(rx_rclk[0]), .ser(rx_ser[0]));
  glca_link_src #(.PHASE(261.0)) glca_link_src_i1 (.pat(pat1),
    .stop(stop1), .rclk(rx_rclk[1]), .ser(rx_ser[1]));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string what, input logic [31:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Classic single Wishbone cycle; holds until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    // Only the bench timeout ends a wait for the answer
    do
      @(posedge clk);
    while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
    chk("wb_ack_drop", 32'h0, {31'h0, ack});
  endtask
  // Samples n serial bits; the word must match some rotation of pat,
  // which an MSB-first or wrong-period stream cannot
  task automatic tx_chk(input int ln, input int n, input logic [19:0] pat);
    logic [19:0] s;
    int r, i, ok, m;
    s = 20'h0;
    ok = 0;
    repeat (300) @(posedge clk);
    for (i = 0; i < n; i++) begin
      s[i] = tx_ser[ln];
      repeat (`GLCA_BIT_DIV) @(posedge clk);
    end
    for (r = 0; r < n; r++) begin
      m = 1;
      for (i = 0; i < n; i++) if (s[i] !== pat[(i + r) % n]) m = 0;
      if (m == 1) ok = 1;
    end
    chk("tx_serial", pat, ok == 1 ? pat : s);
  endtask
  // Mid-point samples of the high and low halves of the pair clock
  task automatic rx_get(output logic [9:0] hi, lo);
    @(posedge clk_t);
    repeat (20) @(posedge clk);
    hi = bus;
    repeat (40) @(posedge clk);
    lo = bus;
  endtask
  task automatic t_regs;
    wb(1'b0, A_C1, 32'h0);
    chk("ctrl1_reset", {16'h0, `GLCA_CTRL1_RST}, rdat);
    wb(1'b0, A_C6, 32'h0);
    chk("ctrl6_reset", {16'h0, `GLCA_CTRL6_RST}, rdat);
    wb(1'b1, A_C1, 32'h5a5a_0180);
    wb(1'b0, A_C1, 32'h0);
    chk("ctrl1_rw", 32'h0000_0180, rdat);
    wb(1'b1, 8'h04, 32'h0000_ffff);
    wb(1'b0, 8'h04, 32'h0);
    chk("unmapped", 32'h0, rdat);
    wb(1'b1, A_C1, 32'h0000_0100);
  endtask
  task automatic t_tx;
    tx_data <= 20'h000b7;
    tx_chk(0, 10, 20'h000b7);
    code_sel <= 1'b1;
    tx_data <= {1'b0, `GLCA_K285, 1'b0, `GLCA_K285};
    tx_chk(1, 20, KPAIR);
    tx_data <= 20'h00100;
    tx_chk(0, 10, {10'h0, `GLCA_INV_CODE});
    code_sel <= 1'b0;
    wb(1'b1, A_C1, 32'h0000_0180);
    tx_data <= {10'h0, 1'b0, `GLCA_K285};
    tx_chk(0, 20, KPAIR);
    wb(1'b1, A_C1, 32'h0000_0100);
    code_sel <= 1'b1;
  endtask
  task automatic t_rx;
    logic [9:0] hi, lo, prev;
    int i, seen;
    seen = 0;
    pat1 <= {10'h289, 10'h17c};
    repeat (1500) @(posedge clk);
    // Consecutive rising-edge words on lane 1 must alternate K and D
    rx_get(prev, lo);
    for (i = 0; i < 6; i++) begin
      rx_get(hi, lo);
      chk("lane0_word", {23'h0, `GLCA_K285}, lo);
      if (hi === {1'b0, `GLCA_D162}) seen = 1;
      chk("lane1_word", prev === 10'h1bc ? 10'h050 : 10'h1bc, hi);
      prev = hi;
    end
    chk("lane1_idle2", 32'h1, seen);
    wb(1'b0, A_ST, 32'h0);
    chk("aligned", 32'h3, rdat[3:2]);
    // Starve lane 1 so its buffer drains; whole IDLE1 sets must fill in
    wb(1'b1, A_C6, 32'h0000_0003);
    stop1 <= 1'b1;
    repeat (800) @(posedge clk);
    seen = 0;
    rx_get(prev, lo);
    for (i = 0; i < 6; i++) begin
      rx_get(hi, lo);
      if (hi === {1'b0, `GLCA_D56}) seen = 1;
      chk("ins_set", prev === 10'h1bc ? 10'h0c5 : 10'h1bc, hi);
      prev = hi;
    end
    chk("ins_idle1", 32'h1, seen);
    stop1 <= 1'b0;
    wb(1'b1, A_C6, 32'h0000_0001);
    pat0 <= 20'h0;
    repeat (1500) @(posedge clk);
    rx_get(hi, lo);
    chk("decode_err", 32'h0ff, lo);
    pat0 <= KPAIR;
  endtask
  task automatic t_nib;
    logic [9:0] hi, lo;
    logic prev;
    int i, n;
    n = 0;
    pat1 <= KPAIR;
    wb(1'b1, A_C1, 32'h0000_0181);
    repeat (1500) @(posedge clk);
    rx_get(hi, lo);
    chk("nib_rise", 32'h39c, hi);
    chk("nib_fall", 32'h1ad, lo);
    // Rate matching is only turned off once nibble mode is in force
    wb(1'b1, A_C6, 32'h0);
    repeat (800) @(posedge clk);
    prev = byte_clk[0];
    for (i = 0; i < 800; i++) begin
      @(posedge clk);
      if (byte_clk[0] === 1'b1 && prev === 1'b0) n++;
      prev = byte_clk[0];
    end
    chk("byte_clk_rate", 32'd10, n);
  endtask
  task stop_test;
    $display("Compared %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // A hang is cut short well beyond the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      stop_test;
    end
  end
  initial begin
    rst_n = 1'b0;
    {cyc, stb, we, code_sel} = 4'h0;
    stop1 = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    sel = 4'h0;
    tx_data = 20'h0;
    pat0 = KPAIR;
    pat1 = KPAIR;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_tx();
    t_rx();
    t_nib();
    stop_test;
  end
endmodule
